//--- core/lpi_defines.svh
/*
 * Shared constants for the LPDDR pin command interface: command codes,
 * address bit positions, widths and timing counts.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef LPI_DEFINES_SVH
`define LPI_DEFINES_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define LPI_ADDR_W 14
`define LPI_BANK_W 2
`define LPI_DQ_W 16
`define LPI_LANES 2
`define LPI_OP_W 14

// ----------------------------------------------------------------------
// command codes {ras_n, cas_n, we_n}
// ----------------------------------------------------------------------
`define LPI_CMD_LMR 3'h0
`define LPI_CMD_REF 3'h1
`define LPI_CMD_PRE 3'h2
`define LPI_CMD_ACT 3'h3
`define LPI_CMD_WR 3'h4
`define LPI_CMD_RD 3'h5
`define LPI_CMD_BST 3'h6
`define LPI_CMD_NOP 3'h7

// ----------------------------------------------------------------------
// address fields
// ----------------------------------------------------------------------
`define LPI_AP_BIT 10
`define LPI_COL_HI 9

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LPI_MCLK_PERIOD_NS 8
`define LPI_LINK_DIV 3
`define LPI_BURST 2

`endif

//--- core/lpi_pkg.sv
/*
 * Types for the LPDDR pin command interface.
 * Assumes lpi_defines.svh is on the include path.
 */
`include "lpi_defines.svh"

package lpi_pkg;
    typedef enum logic [2:0] {
        LPI_OP_NONE,
        LPI_OP_ACT,
        LPI_OP_RD,
        LPI_OP_WR,
        LPI_OP_PRE,
        LPI_OP_LMR,
        LPI_OP_REF
    } lpi_op_t;

    typedef enum logic [1:0] {
        LPI_PWR_ON,
        LPI_PWR_PRE_PD,
        LPI_PWR_ACT_PD
    } lpi_pwr_t;

    function automatic logic [2:0] lpi_cmd_code(input lpi_op_t op);
        case (op)
            LPI_OP_ACT: lpi_cmd_code = `LPI_CMD_ACT;
            LPI_OP_RD: lpi_cmd_code = `LPI_CMD_RD;
            LPI_OP_WR: lpi_cmd_code = `LPI_CMD_WR;
            LPI_OP_PRE: lpi_cmd_code = `LPI_CMD_PRE;
            LPI_OP_LMR: lpi_cmd_code = `LPI_CMD_LMR;
            LPI_OP_REF: lpi_cmd_code = `LPI_CMD_REF;
            default: lpi_cmd_code = `LPI_CMD_NOP;
        endcase
    endfunction : lpi_cmd_code
endpackage : lpi_pkg

//--- core/lpi_link_if.sv
/*
 * Pin-level link between memory controller end and memory device end.
 * Two-way data and strobe pins are resolved here from output enables.
 */
`timescale 1ns/1ps
`include "lpi_defines.svh"

interface lpi_link_if;
    logic clockTrue;
    logic clockComplement;
    logic clkEnableDieA;
    logic clkEnableDieB;
    logic chipSelectDieAN;
    logic chipSelectDieBN;
    logic rasN;
    logic casN;
    logic weN;
    logic bankSel0;
    logic bankSel1;
    logic [`LPI_ADDR_W-1:0] addr;
    logic writeMaskLower;
    logic writeMaskUpper;
    logic [`LPI_DQ_W-1:0] dqCtl;
    logic dqCtlOe;
    logic [`LPI_DQ_W-1:0] dqMem;
    logic dqMemOe;
    logic [`LPI_LANES-1:0] dqsCtl;
    logic dqsCtlOe;
    logic [`LPI_LANES-1:0] dqsMem;
    logic dqsMemOe;
    logic overtempFlag;
    logic [`LPI_DQ_W-1:0] dq;
    logic [`LPI_LANES-1:0] dqs;

    // wire level: the enabling end wins, the device end if both enable; both idle reads as zero
    assign dq = dqMemOe ? dqMem : (dqCtlOe ? dqCtl : '0);
    assign dqs = dqsMemOe ? dqsMem : (dqsCtlOe ? dqsCtl : '0);

    modport ctrl (
        output clockTrue, clockComplement, clkEnableDieA, clkEnableDieB,
        output chipSelectDieAN, chipSelectDieBN, rasN, casN, weN,
        output bankSel0, bankSel1, addr, writeMaskLower, writeMaskUpper,
        output dqCtl, dqCtlOe, dqsCtl, dqsCtlOe,
        input dq, dqs, overtempFlag
    );
    modport mem (
        input clockTrue, clockComplement, clkEnableDieA, clkEnableDieB,
        input chipSelectDieAN, chipSelectDieBN, rasN, casN, weN,
        input bankSel0, bankSel1, addr, writeMaskLower, writeMaskUpper,
        input dq, dqs,
        output dqMem, dqMemOe, dqsMem, dqsMemOe, overtempFlag
    );
endinterface : lpi_link_if

//--- core/lpi_mem_end.sv
/*
 * Memory device end of the LPDDR pin interface: samples commands on the
 * link clock, tracks power state and open banks, keeps a small array,
 * returns read data with edge-aligned strobe.
 * Assumes the link clock runs during commands and bursts; the two data
 * beats of a burst take one period each, beat 0 then beat 1, each from a rise.
 */
// Summary of operation
// - commands sampled at rising true clock only
// - one read data beat per clock period, moved on each rise
// - clock enable low stops buffers and drivers
// - idle banks: precharge power-down, else active
// - clock enable sampled synchronously
// - chip select high masks the command
// - command from select plus three strobes
// - masked beat lanes are not stored
// - bank inputs pick the target bank
// - bank inputs pick mode register, address opcode
// - row on activate, column on access
// - address bit ten requests auto precharge
// - precharge bit ten high closes all
// - read strobe edge aligned, write strobe captures
// - data bus sixteen bits, bidirectional
// - flag raised above temperature threshold
// - only die A enable and select used
// - controller leaves unused address pins alone
`timescale 1ns/1ps
`include "lpi_defines.svh"

module lpi_mem_end
    import lpi_pkg::*;
#(
    parameter int DEPTH_W = 6
) (
    lpi_link_if.mem link,
    input wire logic overTemp,
    output logic [`LPI_OP_W-1:0] modeReg0,
    output logic [`LPI_OP_W-1:0] modeReg1,
    output lpi_pwr_t pwrState
);
    // ------------------------------------------------------------------
    // clocking: device runs on the controller's clock
    // ------------------------------------------------------------------
    logic ck;
    assign ck = link.clockTrue;

    logic [3:0] bankOpen_r;
    logic [`LPI_DQ_W-1:0] mem_r [0:(1<<DEPTH_W)-1];
    logic cke_r;
    logic [1:0] rdBeat_r;
    logic [DEPTH_W-1:0] rdAddr_r;
    logic [1:0] wrBeat_r;
    logic [DEPTH_W-1:0] wrAddr_r;
    logic [2:0] cmd;
    logic cmdValid;
    logic [1:0] bank;

    // die B select and enable are reserved on a single die part
    assign cmd = {link.rasN, link.casN, link.weN};
    assign bank = {link.bankSel1, link.bankSel0};
    assign cmdValid = cke_r && link.clkEnableDieA && !link.chipSelectDieAN;

    function automatic logic [DEPTH_W-1:0] colIdx(input logic [1:0] b,
                                                  input logic [`LPI_ADDR_W-1:0] a);
        // bank kept in the top bits so banks never alias; bit ten never reaches here
        colIdx = {b, a[DEPTH_W-3:0]};
    endfunction : colIdx

    // ------------------------------------------------------------------
    // power state
    // ------------------------------------------------------------------
    always_ff @(posedge ck) begin
        cke_r <= link.clkEnableDieA;
        if (!link.clkEnableDieA) begin
            pwrState <= (bankOpen_r == 4'h0) ? LPI_PWR_PRE_PD : LPI_PWR_ACT_PD;
        end else begin
            pwrState <= LPI_PWR_ON;
        end
    end

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    always_ff @(posedge ck) begin
        if (cmdValid) begin
            case (cmd)
                `LPI_CMD_ACT: begin
                    bankOpen_r[bank] <= 1'b1;
                end
                `LPI_CMD_PRE: begin
                    if (link.addr[`LPI_AP_BIT]) begin
                        bankOpen_r <= 4'h0;
                    end else begin
                        bankOpen_r[bank] <= 1'b0;
                    end
                end
                `LPI_CMD_RD, `LPI_CMD_WR: begin
                    if (link.addr[`LPI_AP_BIT]) begin
                        bankOpen_r[bank] <= 1'b0;
                    end
                end
                `LPI_CMD_LMR: begin
                    if (bank == 2'h0) begin
                        modeReg0 <= link.addr;
                    end else if (bank == 2'h2) begin
                        modeReg1 <= link.addr;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read path: strobe follows the clock, so edges align with data
    // ------------------------------------------------------------------
    always_ff @(posedge ck) begin
        if (cmdValid && cmd == `LPI_CMD_RD) begin
            rdBeat_r <= 2'(`LPI_BURST);
            rdAddr_r <= colIdx(bank, link.addr);
        end else if (rdBeat_r != 2'h0) begin
            rdBeat_r <= rdBeat_r - 2'h1;
            rdAddr_r <= rdAddr_r + 1'b1;
        end
    end

    always_comb begin
        link.dqMemOe = cke_r && (rdBeat_r != 2'h0);
        link.dqsMemOe = link.dqMemOe;
        link.dqMem = link.dqMemOe ? mem_r[rdAddr_r] : '0;
        link.dqsMem = link.dqMemOe ? {`LPI_LANES{ck}} : '0;
    end

    // ------------------------------------------------------------------
    // write path: data captured on both strobe edges, lanes masked
    // ------------------------------------------------------------------
    always_ff @(posedge ck) begin
        if (cmdValid && cmd == `LPI_CMD_WR) begin
            wrBeat_r <= 2'(`LPI_BURST);
            wrAddr_r <= colIdx(bank, link.addr);
        end else if (wrBeat_r != 2'h0) begin
            wrBeat_r <= wrBeat_r - 2'h1;
            wrAddr_r <= wrAddr_r + 1'b1;
        end
    end

    always_ff @(posedge link.dqs[0] or negedge link.dqs[0]) begin
        if (wrBeat_r != 2'h0 && !link.dqMemOe) begin
            if (!link.writeMaskLower) begin
                mem_r[wrAddr_r][7:0] <= link.dq[7:0];
            end
            if (!link.writeMaskUpper) begin
                mem_r[wrAddr_r][15:8] <= link.dq[15:8];
            end
        end
    end

    // ------------------------------------------------------------------
    // temperature flag
    // ------------------------------------------------------------------
    always_comb begin
        link.overtempFlag = overTemp;
    end
endmodule : lpi_mem_end

//--- core/lpi_ctrl_end.sv
/*
 * Controller end of the LPDDR pin interface: divides mclk into the link
 * clock, takes one user request at a time through a handshake, drives
 * commands and write data, returns read data to the mclk domain.
 * Assumes the device end of lpi_link_if on the other side.
 */
`timescale 1ns/1ps
`include "lpi_defines.svh"

module lpi_ctrl_end
    import lpi_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic reqValid,
    input lpi_op_t reqOp,
    input wire logic [1:0] reqBank,
    input wire logic [`LPI_ADDR_W-1:0] reqAddr,
    input wire logic [`LPI_DQ_W-1:0] reqData,
    input wire logic [`LPI_LANES-1:0] reqMask,
    input wire logic powerDown,
    output logic reqReady,
    output logic rspValid,
    output logic [`LPI_DQ_W-1:0] rspData,
    output logic overtempSync,
    lpi_link_if.ctrl link
);
    typedef enum {ST_IDLE, ST_CMD, ST_BEAT, ST_WAIT} lpi_cst_t;
    lpi_cst_t state_r;
    logic [1:0] divCnt_r;
    logic ck_r;
    logic [1:0] otSync_r;
    logic [1:0] beat_r;
    logic pending_r;
    lpi_op_t op_r;

    // ------------------------------------------------------------------
    // link clock divider: commands change on falling ck, centred on rise
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            divCnt_r <= 2'h0;
            ck_r <= 1'b0;
        end else if (divCnt_r == 2'(`LPI_LINK_DIV - 1)) begin
            divCnt_r <= 2'h0;
            ck_r <= ~ck_r;
        end else begin
            divCnt_r <= divCnt_r + 2'h1;
        end
    end
    logic ckFall;
    assign ckFall = ck_r && divCnt_r == 2'(`LPI_LINK_DIV - 1);

    assign link.clockTrue = ck_r;
    assign link.clockComplement = ~ck_r;

    // ------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            reqReady <= 1'b0;
            pending_r <= 1'b0;
            op_r <= LPI_OP_NONE;
            beat_r <= 2'h0;
            link.clkEnableDieA <= 1'b0;
            link.clkEnableDieB <= 1'b0;
            link.chipSelectDieAN <= 1'b1;
            link.chipSelectDieBN <= 1'b1;
            {link.rasN, link.casN, link.weN} <= `LPI_CMD_NOP;
            {link.bankSel1, link.bankSel0} <= 2'h0;
            link.addr <= '0;
            link.dqCtl <= '0;
            link.dqCtlOe <= 1'b0;
            link.dqsCtl <= '0;
            link.dqsCtlOe <= 1'b0;
            {link.writeMaskUpper, link.writeMaskLower} <= 2'h0;
        end else begin
            reqReady <= (state_r == ST_IDLE) && !pending_r && !reqReady;
            if (reqValid && reqReady) begin
                pending_r <= 1'b1;
                op_r <= reqOp;
                {link.bankSel1, link.bankSel0} <= reqBank;
                link.addr <= reqAddr;
                link.dqCtl <= reqData;
                {link.writeMaskUpper, link.writeMaskLower} <= reqMask;
            end
            if (ckFall) begin
                link.clkEnableDieA <= !powerDown;
                link.chipSelectDieAN <= 1'b1;
                {link.rasN, link.casN, link.weN} <= `LPI_CMD_NOP;
                case (state_r)
                    ST_IDLE: begin
                        // enable must stand a period first, else the device's registered
                        // enable is still low and the command is dropped
                        if (pending_r && !powerDown && link.clkEnableDieA) begin
                            link.chipSelectDieAN <= 1'b0;
                            {link.rasN, link.casN, link.weN} <= lpi_cmd_code(op_r);
                            pending_r <= 1'b0;
                            state_r <= ST_CMD;
                        end
                    end
                    ST_CMD: begin
                        beat_r <= 2'(`LPI_BURST);
                        link.dqCtlOe <= (op_r == LPI_OP_WR);
                        link.dqsCtlOe <= (op_r == LPI_OP_WR);
                        state_r <= (op_r == LPI_OP_WR || op_r == LPI_OP_RD) ? ST_BEAT
                                                                           : ST_IDLE;
                    end
                    ST_BEAT: begin
                        beat_r <= beat_r - 2'h1;
                        if (beat_r == 2'h1) begin
                            state_r <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        link.dqCtlOe <= 1'b0;
                        link.dqsCtlOe <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                    default: begin
                        state_r <= ST_IDLE;
                    end
                endcase
            end
            // strobe toggles in the middle of each clock half, giving both edges per period
            if (state_r == ST_BEAT && divCnt_r == 2'h1) begin
                link.dqsCtl <= ~link.dqsCtl;
            end
        end
    end

    // ------------------------------------------------------------------
    // read return and temperature flag crossing
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rspValid <= 1'b0;
            rspData <= '0;
            otSync_r <= 2'h0;
            overtempSync <= 1'b0;
        end else begin
            otSync_r <= {otSync_r[0], link.overtempFlag};
            overtempSync <= otSync_r[1];
            // beat 0 stands from the rise after the command, so it is taken at the
            // fall that leaves ST_CMD; beat 1 one link period later
            rspValid <= ckFall && op_r == LPI_OP_RD && (state_r == ST_CMD
                || (state_r == ST_BEAT && beat_r == 2'(`LPI_BURST)));
            if (ckFall && op_r == LPI_OP_RD && (state_r == ST_CMD
                || (state_r == ST_BEAT && beat_r == 2'(`LPI_BURST)))) begin
                rspData <= link.dq;
            end
        end
    end
endmodule : lpi_ctrl_end

//--- tb/lpi_link_sva.sv
/*
 * Concurrent checks on the pin link between controller and device ends.
 * Assumes the link signals of lpi_link_if and the mclk domain that makes them.
 */
`timescale 1ns/1ps

module lpi_link_sva (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic clockTrue,
    input wire logic clockComplement,
    input wire logic clkEnableDieA,
    input wire logic clkEnableDieB,
    input wire logic chipSelectDieAN,
    input wire logic chipSelectDieBN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic dqCtlOe,
    input wire logic dqMemOe,
    input wire logic dqsCtlOe,
    input wire logic dqsMemOe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    // ------------------------------------------------------------------
    // link clock shape: three mclk high, three low
    // ------------------------------------------------------------------
    sequence s_ckHigh;
        clockTrue [*2];
    endsequence
    sequence s_ckLow;
        !clockTrue [*3];
    endsequence

    a_clk_complement: assert property (clockComplement == !clockTrue)
        else $error("link clock halves not complementary");
    a_clk_period: assert property ($rose(clockTrue) |=> s_ckHigh ##1 s_ckLow ##1 clockTrue)
        else $error("link clock period is not six mclk");

    // ------------------------------------------------------------------
    // command pins
    // ------------------------------------------------------------------
    // changing on the fall keeps the device's rising-edge sample clean
    a_cmd_on_fall: assert property ($changed({chipSelectDieAN, rasN, casN, weN}) |-> $fell(clockTrue))
        else $error("command pins moved away from a falling link clock");
    a_cs_one_period: assert property ($fell(chipSelectDieAN) |=> !chipSelectDieAN [*5])
        else $error("select did not stand one link period");
    a_die_b_unused: assert property (chipSelectDieBN && !clkEnableDieB)
        else $error("second die enable or select used");
    a_pd_no_cmd: assert property (!clkEnableDieA |-> chipSelectDieAN)
        else $error("command issued while clock enable low");

    // ------------------------------------------------------------------
    // two-way data and strobe
    // ------------------------------------------------------------------
    a_no_contention: assert property (dqMemOe |-> !dqCtlOe)
        else $error("both ends drive the data pins");
    a_read_strobe: assert property (dqsMemOe |-> dqMemOe)
        else $error("device strobe driven without read data");
    a_write_strobe: assert property (dqsCtlOe |-> dqCtlOe && clkEnableDieA)
        else $error("write strobe driven without data or enable");
endmodule : lpi_link_sva

//--- tb/test_lpddr_pin_command_interface.sv
/*
 * Self-checking bench: controller end and device end joined by the link.
 * Assumes the user side handshake of lpi_ctrl_end; the device starts unknown.
 */
`timescale 1ns/1ps

module test_lpddr_pin_command_interface
    import lpi_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic reqValid = 1'b0;
    lpi_op_t reqOp = LPI_OP_NONE;
    logic [1:0] reqBank = 2'h0;
    logic [13:0] reqAddr = 14'h0000;
    logic [15:0] reqData = 16'h0000;
    logic [1:0] reqMask = 2'h0;
    logic powerDown = 1'b0;
    logic overTemp = 1'b0;
    logic reqReady, rspValid, overtempSync;
    logic [15:0] rspData;
    logic [13:0] modeReg0, modeReg1;
    lpi_pwr_t pwrState;
    int miscompares = 0;
    int compares = 0;

    always #4 mclk = ~mclk;

    lpi_link_if link ();
    lpi_ctrl_end u_lpi_ctrl_end (.mclk(mclk), .sys_rst(sys_rst), .reqValid(reqValid),
        .reqOp(reqOp), .reqBank(reqBank), .reqAddr(reqAddr), .reqData(reqData),
        .reqMask(reqMask), .powerDown(powerDown), .reqReady(reqReady), .rspValid(rspValid),
        .rspData(rspData), .overtempSync(overtempSync), .link(link));
    lpi_mem_end u_lpi_mem_end (.link(link), .overTemp(overTemp), .modeReg0(modeReg0),
        .modeReg1(modeReg1), .pwrState(pwrState));
    lpi_link_sva u_lpi_link_sva (.mclk(mclk), .sys_rst(sys_rst), .clockTrue(link.clockTrue),
        .clockComplement(link.clockComplement), .clkEnableDieA(link.clkEnableDieA),
        .clkEnableDieB(link.clkEnableDieB), .chipSelectDieAN(link.chipSelectDieAN),
        .chipSelectDieBN(link.chipSelectDieBN), .rasN(link.rasN), .casN(link.casN),
        .weN(link.weN), .dqCtlOe(link.dqCtlOe), .dqMemOe(link.dqMemOe),
        .dqsCtlOe(link.dqsCtlOe), .dqsMemOe(link.dqsMemOe));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task summarize;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // ready is a one-cycle pulse: seen at a fall, taken at the next rise
    task req(input lpi_op_t op, input logic [1:0] b, input logic [13:0] a,
             input logic [15:0] d, input logic [1:0] m);
        int n;
        @(negedge mclk);
        reqOp = op;
        reqBank = b;
        reqAddr = a;
        reqData = d;
        reqMask = m;
        reqValid = 1'b1;
        n = 0;
        while (reqReady !== 1'b1 && n < 3000) begin
            @(negedge mclk);
            n++;
        end
        if (n == 3000) chk({15'h0, reqReady}, 16'h0001);
        @(negedge mclk);
        reqValid = 1'b0;
    endtask : req

    // first beat carries the lower address; the second is let pass
    task rd(input logic [1:0] b, input logic [13:0] a, input logic [15:0] exp);
        int n;
        req(LPI_OP_RD, b, a, 16'h0000, 2'h0);
        n = 0;
        while (rspValid !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
        chk(rspData, exp);
        repeat (24) @(negedge mclk);
    endtask : rd

    task pdCheck(input lpi_pwr_t exp);
        repeat (20) @(negedge mclk);
        powerDown = 1'b1;
        repeat (40) @(negedge mclk);
        chk({14'h0, pwrState}, {14'h0, exp});
        chk({15'h0, link.clkEnableDieA}, 16'h0000);
        powerDown = 1'b0;
        repeat (40) @(negedge mclk);
        chk({14'h0, pwrState}, {14'h0, LPI_PWR_ON});
    endtask : pdCheck

    task endTest(input string name);
        $display("test %s done", name);
    endtask : endTest

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial begin
        // three clock cycles of reset
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        chk({15'h0, link.chipSelectDieAN}, 16'h0001);
        chk({15'h0, link.dqCtlOe}, 16'h0000);
        endTest("reset");

        req(LPI_OP_LMR, 2'h0, 14'h0123, 16'h0000, 2'h0);
        req(LPI_OP_LMR, 2'h2, 14'h2abc, 16'h0000, 2'h0);
        repeat (20) @(negedge mclk);
        chk({2'h0, modeReg0}, 16'h0123);
        chk({2'h0, modeReg1}, 16'h2abc);
        endTest("mode");

        req(LPI_OP_PRE, 2'h0, 14'h0400, 16'h0000, 2'h0);
        req(LPI_OP_REF, 2'h0, 14'h0000, 16'h0000, 2'h0);
        for (int b = 0; b < 4; b++) begin
            req(LPI_OP_ACT, 2'(b), 14'(16'h0010 + b), 16'h0000, 2'h0);
            req(LPI_OP_WR, 2'(b), 14'h0003, 16'(16'h1000 * (b + 1) + 16'h00a5), 2'h0);
        end
        for (int b = 0; b < 4; b++) begin
            rd(2'(b), 14'h0003, 16'(16'h1000 * (b + 1) + 16'h00a5));
        end
        endTest("banks");

        req(LPI_OP_WR, 2'h1, 14'h0003, 16'habcd, 2'h1);
        rd(2'h1, 14'h0003, 16'haba5);
        req(LPI_OP_WR, 2'h2, 14'h0003, 16'h1234, 2'h2);
        rd(2'h2, 14'h0003, 16'h3034);
        endTest("mask");

        req(LPI_OP_WR, 2'h3, 14'h0405, 16'h5aa5, 2'h0);
        req(LPI_OP_ACT, 2'h3, 14'h0013, 16'h0000, 2'h0);
        rd(2'h3, 14'h0005, 16'h5aa5);
        endTest("autoprecharge");

        req(LPI_OP_PRE, 2'h0, 14'h0400, 16'h0000, 2'h0);
        pdCheck(LPI_PWR_PRE_PD);
        req(LPI_OP_ACT, 2'h0, 14'h0020, 16'h0000, 2'h0);
        req(LPI_OP_ACT, 2'h1, 14'h0021, 16'h0000, 2'h0);
        req(LPI_OP_PRE, 2'h1, 14'h0000, 16'h0000, 2'h0);
        pdCheck(LPI_PWR_ACT_PD);
        req(LPI_OP_PRE, 2'h0, 14'h0000, 16'h0000, 2'h0);
        pdCheck(LPI_PWR_PRE_PD);
        endTest("power");

        // a request made while powered down must wait for the wake-up
        powerDown = 1'b1;
        repeat (40) @(negedge mclk);
        fork
            req(LPI_OP_LMR, 2'h0, 14'h0155, 16'h0000, 2'h0);
            begin
                repeat (100) @(negedge mclk);
                chk({2'h0, modeReg0}, 16'h0123);
                powerDown = 1'b0;
            end
        join
        repeat (40) @(negedge mclk);
        chk({2'h0, modeReg0}, 16'h0155);
        endTest("refused");

        overTemp = 1'b1;
        repeat (20) @(negedge mclk);
        chk({15'h0, overtempSync}, 16'h0001);
        overTemp = 1'b0;
        repeat (20) @(negedge mclk);
        chk({15'h0, overtempSync}, 16'h0000);
        endTest("overtemp");
        summarize();
    end

    // about twenty times what the sequence above should need
    initial begin
        #200000;
        miscompares++;
        summarize();
    end
endmodule : test_lpddr_pin_command_interface
